// ---- design/ahp_host_port.sv ----
// Host port, control word and conversion status of the converter
`include "ahp_map.svh"
`timescale 1ns/100ps
`default_nettype none

module ahp_host_port #(
    parameter int W        = 10,
    parameter int ACQ_CYC  = 4,
    parameter int SETL_CYC = 2
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic         cs_n_i,
    input  wire logic         wr_n_i,
    input  wire logic         rd_n_i,
    input  wire logic [W-1:0] data_i,
    output var  logic [W-1:0] data_o,
    output var  logic         data_oe_n_o,
    output var  logic         status_n_o,
    input  wire logic         conv_clk_i,
    input  wire logic         cmp_i,
    output var  logic [W-1:0] dac_code_o,
    output var  logic         hold_o,
    output var  logic [2:0]   chan_sel_o,
    output var  logic         half_scale_o,
    output var  logic         power_down_o
);
    localparam int SW = W + 5;

    // Offset-binary SAR word to two's complement
    function automatic ahp_pkg::ahp_word_t to_twos(input ahp_pkg::ahp_word_t sar);
        to_twos = {~sar[9], sar[8:0]};
    endfunction

    // One successive-approximation decision
    function automatic ahp_pkg::ahp_word_t sar_step(
        input ahp_pkg::ahp_word_t sar,
        input ahp_pkg::ahp_word_t mask,
        input logic               keep
    );
        ahp_pkg::ahp_word_t v;
        v = keep ? sar : (sar & ~mask);
        sar_step = v | (mask >> 1);
    endfunction

    // Strobe edge that counts only while the part is selected
    function automatic logic sel_edge(
        input logic now_lvl,
        input logic was_lvl,
        input logic sel_n
    );
        sel_edge = now_lvl & ~was_lvl & ~sel_n;
    endfunction

    logic [SW-1:0]        pin_s;
    logic                 cs_s;
    logic                 wr_s;
    logic                 rd_s;
    logic                 cclk_s;
    logic                 cmp_s;
    logic [W-1:0]         data_s;
    logic                 cs_d_r;
    logic                 wr_d_r;
    logic                 rd_d_r;
    logic                 cclk_d_r;
    logic [W-1:0]         data_d_r;
    logic                 wr_rise;
    logic                 wr_fall;
    logic                 rd_rise;
    logic                 rd_fall;
    logic                 cclk_rise;
    logic                 rd_active;
    ahp_pkg::ahp_word_t   ctrl_r;
    ahp_pkg::ahp_state_e  state_r;
    logic [2:0]           cnt_r;
    ahp_pkg::ahp_word_t   sar_r;
    ahp_pkg::ahp_word_t   mask_r;
    logic                 second_r;
    logic                 rd_ptr_r;
    logic                 last_done;
    logic                 dual;

    ahp_res_if #(.W(W)) res ();

    // Pin synchronisers, cleared to each pin's idle level so no false
    // strobe edge or select follows reset
    ahp_sync #(
        .W       (SW),
        .RST_VAL ({`AHP_STROBE_IDLE, 2'h0, {W{1'b0}}})
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .d_i       ({cs_n_i, wr_n_i, rd_n_i, conv_clk_i, cmp_i, data_i}),
        .q_o       (pin_s)
    );

    assign cs_s   = pin_s[SW-1];
    assign wr_s   = pin_s[SW-2];
    assign rd_s   = pin_s[SW-3];
    assign cclk_s = pin_s[SW-4];
    assign cmp_s  = pin_s[SW-5];
    assign data_s = pin_s[W-1:0];

    // Result register store
    ahp_res_mem #(.W(W)) u_mem (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .res       (res.mem)
    );

    // Delayed copies for edge detection
    // Reset levels equal the idle pins, so reset makes no edge
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cs_d_r   <= 1'b1;
            wr_d_r   <= 1'b1;
            rd_d_r   <= 1'b1;
            cclk_d_r <= 1'b0;
            data_d_r <= '0;
        end else begin
            cs_d_r   <= cs_s;
            wr_d_r   <= wr_s;
            rd_d_r   <= rd_s;
            cclk_d_r <= cclk_s;
            data_d_r <= data_s;
        end
    end

    // Strobe edges qualified by chip select
    assign wr_rise   = sel_edge(wr_s, wr_d_r, cs_d_r);
    assign wr_fall   = sel_edge(~wr_s, ~wr_d_r, cs_s);
    assign rd_rise   = sel_edge(rd_s, rd_d_r, cs_d_r);
    assign rd_fall   = sel_edge(~rd_s, ~rd_d_r, cs_s);
    assign cclk_rise = cclk_s & ~cclk_d_r;
    assign rd_active = ~cs_s & ~rd_s;

    assign dual      = ctrl_r[`AHP_DUAL_BIT];
    assign last_done = (state_r == ahp_pkg::ST_DONE) && (!dual || second_r);

    // Control word, write-only, cleared at power-on
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_r <= `AHP_CTRL_RST;
        end else if (wr_rise) begin
            ctrl_r <= data_d_r;
        end
    end

    // Conversion sequencer
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r  <= ahp_pkg::ST_IDLE;
            cnt_r    <= 3'h0;
            sar_r    <= `AHP_TRIAL_MSB;
            mask_r   <= `AHP_TRIAL_MSB;
            second_r <= 1'b0;
        end else if (wr_rise) begin
            // A write mid-conversion aborts it and starts afresh
            state_r  <= ahp_pkg::ST_ACQ;
            cnt_r    <= 3'h0;
            second_r <= 1'b0;
        end else begin
            case (state_r)
                ahp_pkg::ST_IDLE: begin
                    cnt_r <= 3'h0;
                end
                ahp_pkg::ST_ACQ: begin
                    // Track for the acquisition count
                    if (cclk_rise) begin
                        if (cnt_r == 3'(ACQ_CYC - 1)) begin
                            state_r <= ahp_pkg::ST_SETTLE;
                            cnt_r   <= 3'h0;
                        end else begin
                            cnt_r <= cnt_r + 3'h1;
                        end
                    end
                end
                ahp_pkg::ST_SETTLE: begin
                    // Settle before the first decision
                    if (cclk_rise) begin
                        if (cnt_r == 3'(SETL_CYC - 1)) begin
                            state_r <= ahp_pkg::ST_BITS;
                            cnt_r   <= 3'h0;
                            sar_r   <= `AHP_TRIAL_MSB;
                            mask_r  <= `AHP_TRIAL_MSB;
                        end else begin
                            cnt_r <= cnt_r + 3'h1;
                        end
                    end
                end
                ahp_pkg::ST_BITS: begin
                    // MSB waits one extra converter clock
                    if (cclk_rise) begin
                        if (mask_r == `AHP_TRIAL_MSB && cnt_r != `AHP_MSB_CYC - 3'h1) begin
                            cnt_r <= cnt_r + 3'h1;
                        end else begin
                            sar_r  <= sar_step(sar_r, mask_r, cmp_s);
                            mask_r <= mask_r >> 1;
                            if (mask_r[0]) begin
                                state_r <= ahp_pkg::ST_DONE;
                            end
                        end
                    end
                end
                ahp_pkg::ST_DONE: begin
                    // Second channel already held, convert it next
                    if (dual && !second_r) begin
                        state_r  <= ahp_pkg::ST_SETTLE;
                        second_r <= 1'b1;
                        cnt_r    <= 3'h0;
                    end else begin
                        state_r <= ahp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ahp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Result store write and read addressing
    assign res.wr_en   = (state_r == ahp_pkg::ST_DONE);
    assign res.wr_addr = second_r ? `AHP_RES_SECOND : `AHP_RES_FIRST;
    assign res.wr_data = to_twos(sar_r);
    assign res.rd_addr = rd_ptr_r;

    // Read pointer steps to the second result after a read in dual mode, and back to the first after the next
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_ptr_r <= `AHP_RES_FIRST;
        end else if (wr_rise) begin
            rd_ptr_r <= `AHP_RES_FIRST;
        end else if (rd_rise) begin
            rd_ptr_r <= dual ? ~rd_ptr_r : `AHP_RES_FIRST;
        end
    end

    // Data port drive
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            data_o      <= `AHP_ZERO_WORD;
            data_oe_n_o <= 1'b1;
        end else begin
            data_o      <= res.rd_data;
            data_oe_n_o <= ~rd_active;
        end
    end

    // Conversion status output, a write's rising edge wins, otherwise set wins over clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            status_n_o <= 1'b1;
        end else if (wr_rise) begin
            status_n_o <= data_d_r[`AHP_MODE_BIT];
        end else if (ctrl_r[`AHP_MODE_BIT]) begin
            if (last_done) begin
                status_n_o <= 1'b0;
            end else if (wr_fall || rd_fall) begin
                status_n_o <= 1'b1;
            end
        end else if (last_done) begin
            status_n_o <= 1'b1;
        end
    end

    // Analog front-end controls
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dac_code_o   <= `AHP_TRIAL_MSB;
            hold_o       <= 1'b0;
            chan_sel_o   <= 3'h0;
            half_scale_o <= 1'b0;
            power_down_o <= 1'b0;
        end else begin
            dac_code_o   <= sar_r;
            hold_o       <= (state_r != ahp_pkg::ST_IDLE) && (state_r != ahp_pkg::ST_ACQ);
            chan_sel_o   <= second_r ? ctrl_r[`AHP_CHB_LSB +: 3] : ctrl_r[`AHP_CHA_LSB +: 3];
            half_scale_o <= ctrl_r[`AHP_HALF_BIT];
            power_down_o <= ctrl_r[`AHP_PD_BIT];
        end
    end
endmodule

`default_nettype wire

// ---- design/ahp_res_mem.sv ----
// Two-word result register store with registered read
`timescale 1ns/100ps
`default_nettype none

module ahp_res_mem #(
    parameter int W = 10
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    ahp_res_if.mem    res
);
    logic [W-1:0] word_r [2];

    // Write port
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            word_r[0] <= '0;
            word_r[1] <= '0;
        end else if (res.wr_en) begin
            word_r[res.wr_addr] <= res.wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            res.rd_data <= '0;
        end else begin
            res.rd_data <= word_r[res.rd_addr];
        end
    end
endmodule

`default_nettype wire

// ---- design/ahp_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module ahp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

`default_nettype wire

// ---- inc/ahp_map.svh ----
// Constants of the host port and conversion status block
`ifndef AHP_MAP_SVH
`define AHP_MAP_SVH

// Control word layout and power-on value
`define AHP_CTRL_W        10
`define AHP_CTRL_RST      10'h000
`define AHP_CHA_LSB       0
`define AHP_CHB_LSB       3
`define AHP_DUAL_BIT      6
`define AHP_HALF_BIT      7
`define AHP_PD_BIT        8
`define AHP_MODE_BIT      9

// Result coding
`define AHP_TRIAL_MSB     10'h200
`define AHP_ZERO_WORD     10'h000

// Converter clock counts per phase
`define AHP_ACQ_CYC       3'h4
`define AHP_SETTLE_CYC    3'h2
`define AHP_MSB_CYC       3'h2

// Result register addresses
`define AHP_RES_FIRST     1'h0
`define AHP_RES_SECOND    1'h1

// Idle level of the select, write and read pins after reset
`define AHP_STROBE_IDLE   3'h7

`endif

// ---- inc/ahp_pkg.sv ----
// Types shared by the host port and conversion status block
package ahp_pkg;

    // Control word and result word
    typedef logic [9:0] ahp_word_t;

    // Conversion sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACQ,
        ST_SETTLE,
        ST_BITS,
        ST_DONE
    } ahp_state_e;

endpackage

// ---- inc/ahp_res_if.sv ----
// Link between the sequencer and the result register store
`timescale 1ns/100ps
`default_nettype none

interface ahp_res_if #(
    parameter int W = 10
);
    logic         wr_en;
    logic         wr_addr;
    logic [W-1:0] wr_data;
    logic         rd_addr;
    logic [W-1:0] rd_data;

    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// ---- test/adc_host_port_status_tb_top.sv ----
// Self-checking bench of the host port block
`timescale 1ns/100ps
`default_nettype none

module adc_host_port_status_tb_top;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            cs_n = 1'b1;
    logic            wr_n = 1'b1;
    logic            rd_n = 1'b1;
    logic [9:0]      hd = 10'h000;
    logic [7:0][9:0] codes = '0;
    wire  [9:0]      dq;
    wire  [9:0]      dac;
    wire  [2:0]      ch;
    wire             oe_n;
    wire             st_n;
    wire             hold;
    wire             half;
    wire             pd;
    wire             cclk;
    wire             cmp;
    int              n_mismatch = 0;
    int              comparisons = 0;

    // System clock
    always #50 clk = ~clk;

    // Design, pins see the shared bus level
    ahp_host_port dut (
        .sys_clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
        .data_i(oe_n ? hd : dq), .data_o(dq), .data_oe_n_o(oe_n), .status_n_o(st_n),
        .conv_clk_i(cclk), .cmp_i(cmp), .dac_code_o(dac), .hold_o(hold), .chan_sel_o(ch),
        .half_scale_o(half), .power_down_o(pd)
    );

    // Analog side
    ahp_adc_model u_adc (
        .sys_clk_i(clk), .dac_code_i(dac), .chan_sel_i(ch), .codes_i(codes),
        .conv_clk_o(cclk), .cmp_o(cmp)
    );

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk_w(input logic [9:0] exp, input logic [9:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t exp %h got %h", $time, exp, got);
        end
    endtask

    task automatic chk_b(input logic exp, input logic got);
        chk_w({9'h000, exp}, {9'h000, got});
    endtask

    // Write strobe, data held around the rise
    task automatic wr(input logic [9:0] d, input logic sel);
        cs_n = ~sel;
        hd = d;
        cyc(3);
        wr_n = 1'b0;
        cyc(4);
        wr_n = 1'b1;
        cyc(4);
        cs_n = 1'b1;
        hd = ~d;
        cyc(1);
    endtask

    // Read strobe, checks enable and word
    task automatic rd(input logic [9:0] exp, input logic sel);
        cs_n = ~sel;
        rd_n = 1'b0;
        cyc(5);
        chk_b(~sel, oe_n);
        if (sel) chk_w(exp, dq);
        rd_n = 1'b1;
        cs_n = 1'b1;
        cyc(5);
    endtask

    // Bounded wait for a status level
    task automatic wait_st(input logic lvl);
        for (int i = 0; i < 400 && st_n !== lvl; i++) cyc(1);
        chk_b(lvl, st_n);
    endtask

    task automatic t_reset;
        chk_b(1'b1, st_n);
        chk_b(1'b1, oe_n);
        chk_w(10'h200, dac);
    endtask

    // Single channel, half-scale and power-down bits set, track then hold
    task automatic t_single;
        codes[5] = 10'h200;
        wr(10'h185, 1'b1);
        wait_st(1'b0);
        chk_w(10'h005, {7'h00, ch});
        chk_w(10'h003, {8'h00, pd, half});
        chk_b(1'b0, hold);
        cyc(30);
        chk_b(1'b1, hold);
        chk_b(1'b0, st_n);
        wait_st(1'b1);
        rd(10'h000, 1'b1);
    endtask

    // Both full-scale ends
    task automatic t_ends;
        for (int i = 0; i < 2; i++) begin
            codes[0] = i ? 10'h000 : 10'h3FF;
            wr(10'h000, 1'b1);
            chk_w(10'h000, {8'h00, pd, half});
            wait_st(1'b1);
            rd(i ? 10'h200 : 10'h1FF, 1'b1);
        end
    endtask

    // Two channels, results in order
    task automatic t_dual;
        codes[1] = 10'h3FF;
        codes[2] = 10'h000;
        wr(10'h051, 1'b1);
        wait_st(1'b1);
        rd(10'h1FF, 1'b1);
        rd(10'h200, 1'b1);
    endtask

    // Strobes without select
    task automatic t_desel;
        wr(10'h200, 1'b0);
        chk_b(1'b1, st_n);
        rd(10'h000, 1'b0);
    endtask

    // Interrupt mode, cleared by read and by a write's falling edge
    task automatic t_int;
        codes[3] = 10'h200;
        wr(10'h203, 1'b1);
        chk_b(1'b1, st_n);
        wait_st(1'b0);
        cyc(8);
        chk_b(1'b0, st_n);
        rd(10'h000, 1'b1);
        chk_b(1'b1, st_n);
        wr(10'h203, 1'b1);
        wait_st(1'b0);
        cs_n = 1'b0;
        hd = 10'h203;
        cyc(3);
        wr_n = 1'b0;
        cyc(4);
        chk_b(1'b1, st_n);
        wr_n = 1'b1;
        cyc(4);
        cs_n = 1'b1;
        cyc(1);
    endtask

    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        cyc(2);
        rst = 1'b0;
        cyc(1);
        t_reset();
        t_single();
        t_ends();
        t_dual();
        t_desel();
        t_int();
        report_and_stop();
    end

    // Watchdog
    initial begin
        #1000000;
        n_mismatch++;
        report_and_stop();
    end
endmodule

`default_nettype wire

// ---- test/ahp_adc_model.sv ----
// Analog front end and converter clock model
`timescale 1ns/100ps
`default_nettype none

module ahp_adc_model (
    input  wire logic            sys_clk_i,
    input  wire logic [9:0]      dac_code_i,
    input  wire logic [2:0]      chan_sel_i,
    input  wire logic [7:0][9:0] codes_i,
    output var  logic            conv_clk_o,
    output var  logic            cmp_o
);
    logic [1:0] div_r = 2'h0;

    // Free running converter clock, quarter rate
    always_ff @(posedge sys_clk_i) begin
        div_r <= div_r + 2'h1;
    end
    assign conv_clk_o = div_r[1];

    // Offset binary level of the selected channel
    assign cmp_o = (codes_i[chan_sel_i] >= dac_code_i);
endmodule

`default_nettype wire

// ---- test/ahp_host_port_sva.sv ----
// Checker of host port strobes and status timing
`timescale 1ns/100ps
`default_nettype none

module ahp_host_port_sva #(
    parameter int W = 10
) (
    input wire logic         sys_clk_i,
    input wire logic         rst_i,
    input wire logic         cs_n_i,
    input wire logic         wr_n_i,
    input wire logic         rd_n_i,
    input wire logic [W-1:0] data_i,
    input wire logic [W-1:0] dac_code_o,
    input wire logic         data_oe_n_o,
    input wire logic         status_n_o
);
    logic mode_r;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Mode bit as last written by a selected host
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_r <= 1'b0;
        end else if ($rose(wr_n_i) && !cs_n_i) begin
            mode_r <= data_i[9];
        end
    end

    sequence sel_wr_rise;
        $rose(wr_n_i) && !cs_n_i;
    endsequence
    sequence sel_wr_fall;
        $fell(wr_n_i) && !cs_n_i;
    endsequence
    sequence sel_rd_fall;
        $fell(rd_n_i) && !cs_n_i;
    endsequence

    AST_RESET_VALUES: assert property ($fell(rst_i) |-> status_n_o && data_oe_n_o && dac_code_o == 10'h200)
        else $error("reset values wrong");
    AST_OE_ON_READ: assert property ($fell(data_oe_n_o) |-> $past(!cs_n_i && !rd_n_i, 2))
        else $error("driver enabled without selected read");
    AST_OE_OFF_DESELECT: assert property (cs_n_i [*4] |=> data_oe_n_o)
        else $error("driver enabled while deselected");
    AST_BUSY_START: assert property (sel_wr_rise and !data_i[9] |-> ##[2:6] !status_n_o)
        else $error("busy not raised after write");
    AST_BUSY_HOLDS: assert property (!mode_r && $fell(status_n_o) |=> !status_n_o [*8])
        else $error("busy too short");
    AST_INT_WRITE_CLEAR: assert property (sel_wr_rise and data_i[9] |-> ##[2:6] status_n_o)
        else $error("interrupt low after write");
    AST_INT_READ_CLEAR: assert property (sel_rd_fall and mode_r |-> ##[2:5] status_n_o)
        else $error("interrupt not cleared by read");
    AST_INT_WRITE_FALL: assert property (sel_wr_fall and mode_r |-> ##[2:5] status_n_o)
        else $error("interrupt not cleared by write");
    AST_WR_IGNORED: assert property ($rose(wr_n_i) && cs_n_i && status_n_o && !mode_r |=> status_n_o [*6])
        else $error("deselected write started conversion");
endmodule

bind ahp_host_port ahp_host_port_sva #(.W(W)) u_ahp_sva (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .wr_n_i(wr_n_i),
    .rd_n_i(rd_n_i), .data_i(data_i), .dac_code_o(dac_code_o),
    .data_oe_n_o(data_oe_n_o), .status_n_o(status_n_o)
);

`default_nettype wire
